// ---- fac_agent.sv ----
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module fac_agent (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt
  output logic             irq,
  // link
  fac_link_if.dev          lnk
);

  // all agent state in one packed struct
  typedef struct packed {
    // ahb data-phase bookkeeping
    logic                          dp_wr;      // pending write
    logic [7:0]                    dp_addr;    // captured address
    logic [31:0]                   rdata;      // registered read data
    // software registers
    logic                          req;        // wants ownership
    logic                          stall;      // own stall request
    logic                          probe_ready;       // debug ready
    logic                          err;        // fatal condition
    logic [fac_pkg::EV_W-1:0]      evt;        // sticky events
    logic [fac_pkg::EV_W-1:0]      mask;       // interrupt mask
    logic [fac_pkg::BPM_W-1:0]     bpm;        // monitor status value
    logic [fac_pkg::BSEL_W-1:0]    bsel;       // frequency select
    // power-on captures
    logic                          cfg_done;   // straps captured
    logic                          cfg_arm;    // first edge seen, straps taken on the next
    logic                          drv_en;
    logic                          obs_en;
    logic                          id0;
    // synchronisers, two stages each
    logic [1:0]                    s_init;
    logic [1:0]                    s_bnr;
    logic [1:0]                    s_pri;
    logic [1:0]                    s_probe_request;
    logic                          pri_d;      // previous priority level
    logic                          probe_request_d;     // previous probe request level
    logic                          init_d;     // previous bus init level
    // arbitration and queue
    fac_pkg::fac_arb_t             arb;
    logic                          locked;     // atomic hold in progress
    logic [fac_pkg::STAT_PEND_W-1:0] pend;     // pending queue entries
    logic                          issue;      // issuing a request this cycle
    logic                          irq;
  } fac_dev_t;

  fac_dev_t st_ff;
  fac_dev_t nxt_st;

  // one queue entry, sized to the pending count
  localparam logic [fac_pkg::STAT_PEND_W-1:0] PEND_ONE = 4'h1;

  // byte address decode used by both read and write paths
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  logic        ap_valid;  // address phase accepted
  logic        init_obs;  // synchronised bus init level
  logic        bnr_obs;   // synchronised stall level
  logic        pri_obs;   // synchronised priority request
  logic        probe_request_obs;  // synchronised probe request
  logic        can_issue; // owner allowed to issue
  logic [31:0] rd_mux;    // read value for next data phase
  logic [fac_pkg::EV_W-1:0] ev_set;  // events this cycle

  always_comb begin
    ap_valid  = hsel && hready && (htrans == fac_pkg::HTRANS_NONSEQ);
    init_obs  = st_ff.s_init[1];
    bnr_obs   = st_ff.s_bnr[1];
    pri_obs   = st_ff.s_pri[1];
    probe_request_obs  = st_ff.s_probe_request[1];
    // stall blocks every new issue; priority blocks new issues unless locked
    can_issue = (st_ff.arb == fac_pkg::ARB_OWN) && !bnr_obs &&
                (!pri_obs || st_ff.locked) && (st_ff.pend != '0);
  end

  // read mux, chosen in the address phase and registered for the data phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_reg(haddr, fac_pkg::CTRL_OFS)) begin
      rd_mux[fac_pkg::CTRL_REQ_BIT]   = st_ff.req;
      rd_mux[fac_pkg::CTRL_STALL_BIT] = st_ff.stall;
      rd_mux[fac_pkg::CTRL_PROBE_READY_BIT]  = st_ff.probe_ready;
      rd_mux[fac_pkg::CTRL_ERR_BIT]   = st_ff.err;
    end else if (is_reg(haddr, fac_pkg::STAT_OFS)) begin
      rd_mux[fac_pkg::STAT_OWN_BIT] = (st_ff.arb == fac_pkg::ARB_OWN);
      rd_mux[fac_pkg::STAT_PRI_BIT] = pri_obs;
      rd_mux[fac_pkg::STAT_STL_BIT] = bnr_obs;
      rd_mux[fac_pkg::STAT_DRV_BIT] = st_ff.drv_en;
      rd_mux[fac_pkg::STAT_OBS_BIT] = st_ff.obs_en;
      rd_mux[fac_pkg::STAT_ID0_BIT] = st_ff.id0;
      rd_mux[fac_pkg::STAT_PEND_LSB +: fac_pkg::STAT_PEND_W] = st_ff.pend;
      rd_mux[fac_pkg::STAT_PROBE_REQUEST_BIT] = probe_request_obs;
    end else if (is_reg(haddr, fac_pkg::IRQ_OFS)) begin
      rd_mux[fac_pkg::EV_W-1:0] = st_ff.evt;
    end else if (is_reg(haddr, fac_pkg::MASK_OFS)) begin
      rd_mux[fac_pkg::EV_W-1:0] = st_ff.mask;
    end else if (is_reg(haddr, fac_pkg::BPM_OFS)) begin
      rd_mux[fac_pkg::BPM_W-1:0] = st_ff.bpm;
    end else if (is_reg(haddr, fac_pkg::BSEL_OFS)) begin
      rd_mux[fac_pkg::BSEL_W-1:0] = st_ff.bsel;
    end
  end

  // next state of the whole agent
  always_comb begin
    nxt_st = st_ff;
    ev_set = '0;
    // ahb address phase capture; unmapped reads give zero, writes are dropped
    nxt_st.dp_wr   = ap_valid && hwrite;
    nxt_st.dp_addr = haddr;
    if (ap_valid && !hwrite) begin
      nxt_st.rdata = rd_mux;
    end
    // synchronise the bus init, stall, priority and probe request inputs before use
    nxt_st.s_init = {st_ff.s_init[0], (lnk.bus_init_error_n == fac_pkg::ASSERTED)};
    nxt_st.s_bnr  = {st_ff.s_bnr[0], (lnk.block_next_request_n == fac_pkg::ASSERTED)};
    nxt_st.s_pri  = {st_ff.s_pri[0], (lnk.priority_bus_request_n == fac_pkg::ASSERTED)};
    nxt_st.s_probe_request = {st_ff.s_probe_request[0],
                     (lnk.breakpoint_monitor_n[fac_pkg::PROBE_REQUEST_IX] == fac_pkg::ASSERTED)};
    nxt_st.pri_d  = pri_obs;
    nxt_st.probe_request_d = probe_request_obs;
    nxt_st.init_d = init_obs;
    // straps captured once, on the second edge after reset release: the far
    // end's strap registers only load on the first one
    nxt_st.cfg_arm = 1'b1;
    if (st_ff.cfg_arm && !st_ff.cfg_done) begin
      nxt_st.cfg_done = 1'b1;
      nxt_st.drv_en   = lnk.cfg_drv_en;
      nxt_st.obs_en   = lnk.cfg_obs_en;
      nxt_st.id0      = (lnk.system_request_zero_n == fac_pkg::ASSERTED);
    end
    // arbitration state machine
    nxt_st.issue = 1'b0;
    case (st_ff.arb)
      fac_pkg::ARB_IDLE: begin
        if (st_ff.req || st_ff.pend != '0) begin
          nxt_st.arb = fac_pkg::ARB_REQ;  // re-arbitrates for leftover entries
        end
      end
      fac_pkg::ARB_REQ: begin
        // granted once no priority agent holds the bus
        if (!pri_obs) begin
          nxt_st.arb = fac_pkg::ARB_OWN;
          ev_set[fac_pkg::EV_GRANT_BIT] = 1'b1;
        end
      end
      fac_pkg::ARB_OWN: begin
        if (can_issue) begin
          nxt_st.issue = 1'b1;
          nxt_st.pend  = st_ff.pend - PEND_ONE;
        end else if (!st_ff.req && st_ff.pend == '0) begin
          nxt_st.arb = fac_pkg::ARB_IDLE;
        end
      end
      default: begin
        nxt_st.arb = fac_pkg::ARB_IDLE;
      end
    endcase
    // observed bus init resets lock and arbitration, queue is kept
    if (st_ff.obs_en && init_obs) begin
      nxt_st.arb    = fac_pkg::ARB_IDLE;
      nxt_st.locked = 1'b0;
      nxt_st.issue  = 1'b0;
      nxt_st.pend   = st_ff.pend;
    end
    // events on rising edges of observed levels
    ev_set[fac_pkg::EV_INIT_BIT] = init_obs && !st_ff.init_d;
    ev_set[fac_pkg::EV_PROBE_REQUEST_BIT] = probe_request_obs && !st_ff.probe_request_d;
    ev_set[fac_pkg::EV_PRI_BIT]  = pri_obs && !st_ff.pri_d;
    // ahb data-phase writes
    if (st_ff.dp_wr) begin
      if (is_reg(st_ff.dp_addr, fac_pkg::CTRL_OFS)) begin
        nxt_st.req   = hwdata[fac_pkg::CTRL_REQ_BIT];
        nxt_st.stall = hwdata[fac_pkg::CTRL_STALL_BIT];
        nxt_st.probe_ready  = hwdata[fac_pkg::CTRL_PROBE_READY_BIT];
        nxt_st.err   = hwdata[fac_pkg::CTRL_ERR_BIT];
        // completion pulse adds a queue entry; locked flag set only by request and error bits together
        if (hwdata[fac_pkg::CTRL_CMPL_BIT] && (&st_ff.pend) == 1'b0) begin
          nxt_st.pend = nxt_st.pend + PEND_ONE;
        end
        nxt_st.locked = hwdata[fac_pkg::CTRL_REQ_BIT] && hwdata[fac_pkg::CTRL_ERR_BIT];
      end else if (is_reg(st_ff.dp_addr, fac_pkg::IRQ_OFS)) begin
        nxt_st.evt = st_ff.evt & ~hwdata[fac_pkg::EV_W-1:0];
      end else if (is_reg(st_ff.dp_addr, fac_pkg::MASK_OFS)) begin
        nxt_st.mask = hwdata[fac_pkg::EV_W-1:0];
      end else if (is_reg(st_ff.dp_addr, fac_pkg::BPM_OFS)) begin
        nxt_st.bpm = hwdata[fac_pkg::BPM_W-1:0];
      end else if (is_reg(st_ff.dp_addr, fac_pkg::BSEL_OFS)) begin
        nxt_st.bsel = hwdata[fac_pkg::BSEL_W-1:0];
      end
    end
    // set wins over write-one-to-clear
    nxt_st.evt = nxt_st.evt | ev_set;
    nxt_st.irq = |(nxt_st.evt & nxt_st.mask);
  end

  // register the struct
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff      <= '0;
      st_ff.bsel <= fac_pkg::BSEL_RST;  // 100 MHz bus clock code
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ahb answers: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_ff.rdata;
  assign irq       = st_ff.irq;

  // link drive, all active low; bus init only when driver enabled
  assign lnk.bus_init_error_o_dev      = fac_pkg::ASSERTED;
  assign lnk.bus_init_error_oe_dev     = st_ff.drv_en && st_ff.err;
  assign lnk.block_next_request_oe_dev = st_ff.stall;
  // request line driven only after straps are sampled, so identity sees the strap
  assign lnk.symmetric_bus_request_o   = fac_pkg::ASSERTED;
  assign lnk.symmetric_bus_request_oe  = st_ff.cfg_done &&
                                         (st_ff.arb != fac_pkg::ARB_IDLE);
  // monitor lines 0..4 are outputs, line 5 left as input
  assign lnk.breakpoint_monitor_o = {1'b1, !st_ff.probe_ready, ~st_ff.bpm[fac_pkg::PROBE_READY_IX-1:0]};
  assign lnk.breakpoint_monitor_oe = {1'b0, {(fac_pkg::BPM_W-1){1'b1}}};
  assign lnk.bus_frequency_select = st_ff.bsel;

endmodule

// ---- fac_asserts.sv ----
`timescale 1ns/10ps
// watches the shared link lines between agent and chipset
module fac_asserts (
  // clock and reset
  input logic       hclk,
  input logic       hresetn,
  // link lines
  input logic       bus_init_error_oe_dev,
  input logic       bus_init_error_n,
  input logic       block_next_request_oe_cs,
  input logic       block_next_request_n,
  input logic       symmetric_bus_request_o,
  input logic       symmetric_bus_request_oe,
  input logic       system_request_zero_n,
  input logic       probe_request_n,
  input logic [5:0] breakpoint_monitor_n,
  input logic [1:0] bus_frequency_select,
  input logic       cfg_drv_en,
  input logic       cfg_obs_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // first edge after reset release, when straps are still presented
  sequence rel_s;
    $rose(hresetn);
  endsequence
  init_drv_a: assert property (bus_init_error_oe_dev |-> cfg_drv_en)
    else $error("bus init driven while driver disabled");
  init_low_a: assert property (bus_init_error_oe_dev |-> !bus_init_error_n)
    else $error("bus init not low while driven");
  stall_low_a: assert property (block_next_request_oe_cs |-> !block_next_request_n)
    else $error("stall line not low while driven");
  req_wire_a: assert property (symmetric_bus_request_oe |->
    system_request_zero_n == symmetric_bus_request_o)
    else $error("request wire differs from driven value");
  id_strap_a: assert property (rel_s |-> !system_request_zero_n)
    else $error("identity strap not low at reset release");
  bsel_rst_a: assert property (rel_s |-> bus_frequency_select == fac_pkg::BSEL_RST)
    else $error("frequency select reset code wrong");
  probe_request_map_a: assert property (breakpoint_monitor_n[5] == probe_request_n)
    else $error("monitor line 5 differs from probe request");
  cfg_hold_a: assert property (!$past(hresetn, 3) ||
    ($stable(cfg_drv_en) && $stable(cfg_obs_en)))
    else $error("power-on enables changed after capture");
endmodule

// ---- fac_chipset.sv ----
`timescale 1ns/10ps
// chipset / priority agent end: drives priority request, stall, debug request,
// and the power-on straps; reports what it sees on the shared lines
module fac_chipset (
  // clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // user side
  input  wire logic                      pri_want,       // priority work pending
  input  wire logic                      pri_done,       // all priority requests done
  input  wire logic                      cs_stall,       // chipset cannot accept
  input  wire logic                      dbg_req,        // debug tool request
  input  wire logic                      cs_err,         // chipset detects fatal error
  input  wire logic                      strap_drv,      // power-on driver enable
  input  wire logic                      strap_obs,      // power-on observe enable
  output logic                           cs_pri_active,  // holding priority request
  output logic                           cs_init_seen,   // bus init sampled low
  output logic                           cs_dev_req,     // device requesting bus
  output logic                           cs_dev_ready,   // probe ready seen
  output logic [fac_pkg::BSEL_W-1:0]     cs_bsel,        // frequency code seen
  // link
  fac_link_if.cs                         lnk
);

  typedef struct packed {
    logic                      pri;
    logic                      stall;
    logic                      dbg;
    logic                      err;
    logic                      drv;
    logic                      obs;
    logic                      strap_arm;  // first edge after reset seen
    logic                      strap_rel;  // strap released after reset
    logic [1:0]                s_init;     // synchroniser for bus init
    logic [1:0]                s_req;      // synchroniser for device request
    logic [1:0]                s_rdy;      // synchroniser for probe ready
    logic                      init_seen;
    logic                      dev_req;
    logic                      dev_rdy;
    logic [fac_pkg::BSEL_W-1:0] bsel;
  } fac_cs_t;

  fac_cs_t st_ff;
  fac_cs_t nxt_st;

  // next state: priority request held from want until done
  always_comb begin
    nxt_st = st_ff;
    if (pri_want) begin
      nxt_st.pri = 1'b1;
    end else if (pri_done) begin
      nxt_st.pri = 1'b0;  // release only when all requests finished
    end
    nxt_st.stall     = cs_stall;
    nxt_st.dbg       = dbg_req;
    nxt_st.err       = cs_err;
    nxt_st.drv       = strap_drv;
    nxt_st.obs       = strap_obs;
    nxt_st.strap_arm = 1'b1;
    // strap held one edge longer, so the agent samples it once its enables settle
    nxt_st.strap_rel = st_ff.strap_arm;
    nxt_st.s_init    = {st_ff.s_init[0], !lnk.bus_init_error_n};
    nxt_st.s_req     = {st_ff.s_req[0], !lnk.system_request_zero_n};
    nxt_st.s_rdy     = {st_ff.s_rdy[0], !lnk.breakpoint_monitor_n[fac_pkg::PROBE_READY_IX]};
    nxt_st.init_seen = st_ff.s_init[1];
    nxt_st.dev_req   = st_ff.s_req[1];
    nxt_st.dev_rdy   = st_ff.s_rdy[1];
    nxt_st.bsel      = lnk.bus_frequency_select;
  end

  // single register bank, every edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // stall, bus init and strap pulled low through enables; priority and probe request driven directly
  assign lnk.priority_bus_request_n   = !st_ff.pri;
  assign lnk.block_next_request_oe_cs = st_ff.stall;
  assign lnk.probe_request_n          = !st_ff.dbg;
  assign lnk.bus_init_error_oe_cs     = st_ff.err;
  assign lnk.cfg_drv_en               = st_ff.drv;
  assign lnk.cfg_obs_en               = st_ff.obs;
  // strap pulls request low until second edge after reset, giving identity 0
  assign lnk.strap_id_oe_cs           = !st_ff.strap_rel;

  assign cs_pri_active = st_ff.pri;
  assign cs_init_seen  = st_ff.init_seen;
  assign cs_dev_req    = st_ff.dev_req;
  assign cs_dev_ready  = st_ff.dev_rdy;
  assign cs_bsel       = st_ff.bsel;

endmodule

// ---- fac_link_if.sv ----
`timescale 1ns/10ps
// shared front-side-bus control lines between the processor agent and the chipset
interface fac_link_if;
  // bus init, open drain from both ends
  logic bus_init_error_o_dev;
  logic bus_init_error_oe_dev;
  logic bus_init_error_oe_cs;
  logic bus_init_error_n;      // resolved wire level
  // block next request, open drain from both ends
  logic block_next_request_oe_dev;
  logic block_next_request_oe_cs;
  logic block_next_request_n;  // resolved wire level
  // symmetric request, driven by device, sampled at reset for identity
  logic symmetric_bus_request_o;
  logic symmetric_bus_request_oe;
  logic system_request_zero_n;  // resolved wire (chipset pulls low at reset for id 0)
  logic strap_id_oe_cs;
  // priority request from chipset
  logic priority_bus_request_n;
  // breakpoint monitor lines
  logic [fac_pkg::BPM_W-1:0] breakpoint_monitor_o;
  logic [fac_pkg::BPM_W-1:0] breakpoint_monitor_oe;
  logic                      probe_request_n;   // driven by debug tool side
  logic [fac_pkg::BPM_W-1:0] breakpoint_monitor_n;
  // frequency select
  logic [fac_pkg::BSEL_W-1:0] bus_frequency_select;
  // power-on configuration straps, provided by chipset
  logic cfg_drv_en;
  logic cfg_obs_en;

  // open-drain resolution for bus init, stall and request: any enabled driver pulls low; monitor lines pass straight through
  assign bus_init_error_n = !(bus_init_error_oe_dev || bus_init_error_oe_cs);
  assign block_next_request_n = !(block_next_request_oe_dev || block_next_request_oe_cs);
  assign system_request_zero_n = symmetric_bus_request_oe ? symmetric_bus_request_o :
                                 !strap_id_oe_cs;
  assign breakpoint_monitor_n[fac_pkg::PROBE_REQUEST_IX] = probe_request_n;
  assign breakpoint_monitor_n[fac_pkg::PROBE_READY_IX:0] =
    breakpoint_monitor_o[fac_pkg::PROBE_READY_IX:0];

  modport dev (
    output bus_init_error_o_dev, bus_init_error_oe_dev, block_next_request_oe_dev,
    output symmetric_bus_request_o, symmetric_bus_request_oe,
    output breakpoint_monitor_o, breakpoint_monitor_oe, bus_frequency_select,
    input  bus_init_error_n, block_next_request_n, system_request_zero_n,
    input  priority_bus_request_n, breakpoint_monitor_n, cfg_drv_en, cfg_obs_en
  );
  modport cs (
    output bus_init_error_oe_cs, block_next_request_oe_cs, strap_id_oe_cs,
    output priority_bus_request_n, probe_request_n, cfg_drv_en, cfg_obs_en,
    input  bus_init_error_n, block_next_request_n, system_request_zero_n,
    input  breakpoint_monitor_n, bus_frequency_select
  );
endinterface

// ---- fac_pkg.sv ----
package fac_pkg;

  // ---------------------------------------------------------------------------
  // ahb-lite register offsets for the agent controller (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;  // control: request, stall, probe ready
  localparam logic [7:0] STAT_OFS   = 8'h04;  // live state readback
  localparam logic [7:0] IRQ_OFS    = 8'h08;  // sticky events, write one to clear
  localparam logic [7:0] MASK_OFS   = 8'h0C;  // interrupt mask, same layout as IRQ
  localparam logic [7:0] BPM_OFS    = 8'h10;  // breakpoint monitor status value
  localparam logic [7:0] BSEL_OFS   = 8'h14;  // bus frequency select value

  // ---------------------------------------------------------------------------
  // control register field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_REQ_BIT   = 0;  // software wants bus ownership
  localparam int CTRL_STALL_BIT = 1;  // software cannot accept new transactions
  localparam int CTRL_PROBE_READY_BIT  = 2;  // debug ready indication
  localparam int CTRL_ERR_BIT   = 3;  // fatal bus condition, drive bus init
  localparam int CTRL_CMPL_BIT  = 4;  // adds one pending queue entry (pulse)

  // ---------------------------------------------------------------------------
  // status register field positions
  // ---------------------------------------------------------------------------
  localparam int STAT_OWN_BIT   = 0;  // agent owns the bus
  localparam int STAT_PRI_BIT   = 1;  // priority request seen
  localparam int STAT_STL_BIT   = 2;  // bus stalled
  localparam int STAT_DRV_BIT   = 3;  // bus-init driver enabled at power on
  localparam int STAT_OBS_BIT   = 4;  // bus-init observation enabled at power on
  localparam int STAT_ID0_BIT   = 5;  // agent identity is 0
  localparam int STAT_PEND_LSB  = 8;  // pending queue count field
  localparam int STAT_PEND_W    = 4;  // pending queue count width
  localparam int STAT_PROBE_REQUEST_BIT  = 12; // probe request seen

  // ---------------------------------------------------------------------------
  // interrupt event bit positions
  // ---------------------------------------------------------------------------
  localparam int EV_INIT_BIT  = 0;  // bus init observed
  localparam int EV_PROBE_REQUEST_BIT  = 1;  // probe request asserted
  localparam int EV_PRI_BIT   = 2;  // priority request asserted
  localparam int EV_GRANT_BIT = 3;  // ownership gained
  localparam int EV_W         = 4;  // event vector width

  // ---------------------------------------------------------------------------
  // fixed widths and levels
  // ---------------------------------------------------------------------------
  localparam int BPM_W   = 6;  // breakpoint monitor width
  localparam int PROBE_READY_IX = 4;  // monitor line used as probe ready
  localparam int PROBE_REQUEST_IX = 5;  // monitor line used as probe request
  localparam int BSEL_W  = 2;  // bus frequency select width
  localparam logic [BSEL_W-1:0] BSEL_RST = 2'h1;  // reset code for 100 MHz bus clock
  localparam logic ASSERTED = 1'b0;               // all control lines active low
  localparam logic NEGATED  = 1'b1;

  // ahb-lite transfer codes
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // symmetric arbitration states
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,  // not requesting
    ARB_REQ  = 2'b01,  // request driven, waiting for clear bus
    ARB_OWN  = 2'b10   // owning, may issue
  } fac_arb_t;

endpackage

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq, hrdy;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic pri_want = 0, pri_done = 0, cs_stall = 0, dbg_req = 0, cs_err = 0;
  logic cs_pri_active, cs_init_seen, cs_dev_req, cs_dev_ready;
  logic [1:0] cs_bsel;
  int fails = 0, n_tests = 0, cyc = 0;
  always #12.5 hclk = ~hclk;
  fac_link_if lnk ();
  fac_agent fac_agent_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(), .irq(irq), .lnk(lnk));
  // straps both enabled so every bus-init path is reachable
  fac_chipset fac_chipset_i (.hclk(hclk), .hresetn(hresetn), .pri_want(pri_want),
    .pri_done(pri_done), .cs_stall(cs_stall), .dbg_req(dbg_req), .cs_err(cs_err),
    .strap_drv(1'b1), .strap_obs(1'b1), .cs_pri_active(cs_pri_active),
    .cs_init_seen(cs_init_seen), .cs_dev_req(cs_dev_req), .cs_dev_ready(cs_dev_ready),
    .cs_bsel(cs_bsel), .lnk(lnk));
  fac_asserts fac_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .bus_init_error_oe_dev(lnk.bus_init_error_oe_dev), .bus_init_error_n(lnk.bus_init_error_n),
    .block_next_request_oe_cs(lnk.block_next_request_oe_cs),
    .block_next_request_n(lnk.block_next_request_n),
    .symmetric_bus_request_o(lnk.symmetric_bus_request_o),
    .symmetric_bus_request_oe(lnk.symmetric_bus_request_oe),
    .system_request_zero_n(lnk.system_request_zero_n), .probe_request_n(lnk.probe_request_n),
    .breakpoint_monitor_n(lnk.breakpoint_monitor_n),
    .bus_frequency_select(lnk.bus_frequency_select),
    .cfg_drv_en(lnk.cfg_drv_en), .cfg_obs_en(lnk.cfg_obs_en));
  task automatic end_of_test;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one ahb single transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; haddr <= a; hwrite <= w; htrans <= fac_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 0; htrans <= fac_pkg::HTRANS_IDLE; hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  // link state lags a few cycles, so poll a bounded number of reads
  task automatic rs(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 20; i++) begin
      bus(0, a, 32'h0);
      if ((q & m) === e) break;
    end
    chk(q & m, e);
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rs(fac_pkg::STAT_OFS, 32'h38, 32'h38);
    rs(fac_pkg::BSEL_OFS, 32'h3, 32'h1);
    rs(8'h18, 32'hFFFFFFFF, 32'h0);
    bus(1, fac_pkg::MASK_OFS, 32'hF);
    bus(1, fac_pkg::CTRL_OFS, 32'h1);
    rs(fac_pkg::STAT_OFS, 32'h1, 32'h1);
    rs(fac_pkg::IRQ_OFS, 32'h8, 32'h8);
    chk({cs_dev_req, irq}, 2'h3);
    bus(1, fac_pkg::IRQ_OFS, 32'hF);
    rs(fac_pkg::IRQ_OFS, 32'hF, 32'h0);
    chk(irq, 1'b0);
    pri_want <= 1;
    rs(fac_pkg::STAT_OFS, 32'h2, 32'h2);
    chk(cs_pri_active, 1'b1);
    bus(1, fac_pkg::CTRL_OFS, 32'h11);
    repeat (8) @(posedge hclk);
    rs(fac_pkg::STAT_OFS, 32'hF00, 32'h100);
    pri_want <= 0; pri_done <= 1; cs_stall <= 1;
    rs(fac_pkg::STAT_OFS, 32'h6, 32'h4);
    repeat (8) @(posedge hclk);
    rs(fac_pkg::STAT_OFS, 32'hF00, 32'h100);
    cs_err <= 1;
    rs(fac_pkg::IRQ_OFS, 32'h1, 32'h1);
    rs(fac_pkg::STAT_OFS, 32'hF01, 32'h100);
    cs_err <= 0; cs_stall <= 0;
    rs(fac_pkg::STAT_OFS, 32'hF01, 32'h1);
    dbg_req <= 1;
    rs(fac_pkg::STAT_OFS, 32'h1000, 32'h1000);
    rs(fac_pkg::IRQ_OFS, 32'h2, 32'h2);
    bus(1, fac_pkg::CTRL_OFS, 32'h5);
    repeat (6) @(posedge hclk);
    chk(cs_dev_ready, 1'b1);
    bus(1, fac_pkg::CTRL_OFS, 32'h9);
    repeat (6) @(posedge hclk);
    chk(cs_init_seen, 1'b1);
    bus(1, fac_pkg::BSEL_OFS, 32'h2);
    repeat (6) @(posedge hclk);
    chk(cs_bsel, 2'h2);
    bus(1, fac_pkg::BPM_OFS, 32'h3F);
    rs(fac_pkg::BPM_OFS, 32'h3F, 32'h3F);
    chk(lnk.breakpoint_monitor_n[3:0], 4'h0);
    bus(1, fac_pkg::CTRL_OFS, 32'h2);
    rs(fac_pkg::STAT_OFS, 32'h4, 32'h4);
    end_of_test;
  end
endmodule
